/* src/icr_pkg.sv */
package icr_pkg;

  // ----------------------------------------------------------------
  // Request codes and answers
  // ----------------------------------------------------------------
  localparam logic [7:0] ICR_FN_READ = 8'h03;
  localparam logic [7:0] ICR_FN_WRITE = 8'h06;
  localparam logic [7:0] ICR_EX_NONE = 8'h00;
  localparam logic [7:0] ICR_EX_FUNC = 8'h01;
  localparam logic [7:0] ICR_EX_ADDR = 8'h02;
  localparam logic [7:0] ICR_EX_VALUE = 8'h03;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ICR_OFS_CH1_WIN = 16'h0004;
  localparam logic [15:0] ICR_OFS_CH1_OSC = 16'h0006;
  localparam logic [15:0] ICR_OFS_CH2_WIN = 16'h0014;
  localparam logic [15:0] ICR_OFS_DEV_ADDR = 16'h0021;
  localparam logic [15:0] ICR_OFS_RATE = 16'h0022;
  localparam logic [15:0] ICR_OFS_IP_HI = 16'h0031;
  localparam logic [15:0] ICR_OFS_IP_LO = 16'h0032;
  localparam logic [15:0] ICR_OFS_MASK_HI = 16'h0033;
  localparam logic [15:0] ICR_OFS_MASK_LO = 16'h0034;
  localparam logic [15:0] ICR_OFS_DHCP = 16'h003a;
  localparam logic [15:0] ICR_OFS_BIP_HI = 16'h003c;
  localparam logic [15:0] ICR_OFS_BIP_LO = 16'h003d;
  localparam logic [15:0] ICR_OFS_BMASK_HI = 16'h003e;
  localparam logic [15:0] ICR_OFS_BMASK_LO = 16'h003f;
  localparam logic [15:0] ICR_OFS_BOOT_SEL = 16'h0042;
  localparam logic [15:0] ICR_OFS_SAVE = 16'h0043;

  // ----------------------------------------------------------------
  // Storage indices
  // ----------------------------------------------------------------
  localparam int ICR_NREG = 16;
  typedef logic [3:0] icr_idx_t;
  localparam icr_idx_t ICR_I_CH1_WIN = 4'h0;
  localparam icr_idx_t ICR_I_CH1_OSC = 4'h1;
  localparam icr_idx_t ICR_I_CH2_WIN = 4'h2;
  localparam icr_idx_t ICR_I_DEV_ADDR = 4'h3;
  localparam icr_idx_t ICR_I_RATE = 4'h4;
  localparam icr_idx_t ICR_I_IP_HI = 4'h5;
  localparam icr_idx_t ICR_I_IP_LO = 4'h6;
  localparam icr_idx_t ICR_I_MASK_HI = 4'h7;
  localparam icr_idx_t ICR_I_MASK_LO = 4'h8;
  localparam icr_idx_t ICR_I_DHCP = 4'h9;
  localparam icr_idx_t ICR_I_BIP_HI = 4'ha;
  localparam icr_idx_t ICR_I_BIP_LO = 4'hb;
  localparam icr_idx_t ICR_I_BMASK_HI = 4'hc;
  localparam icr_idx_t ICR_I_BMASK_LO = 4'hd;
  localparam icr_idx_t ICR_I_BOOT_SEL = 4'he;
  localparam icr_idx_t ICR_I_SAVE = 4'hf;

  // ----------------------------------------------------------------
  // Limits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ICR_FLAG_OFF = 16'h0000;
  localparam logic [15:0] ICR_FLAG_ON = 16'h0001;
  localparam logic [15:0] ICR_RATE_MAX = 16'h0006;
  localparam logic [15:0] ICR_RATE_DEFAULT = 16'h0006;
  localparam logic [15:0] ICR_ADDR_MIN = 16'h0001;
  localparam logic [15:0] ICR_ADDR_MAX = 16'h00fe;
  localparam logic [15:0] ICR_ADDR_DEFAULT = 16'h0001;
  localparam logic [15:0] ICR_WIN_MIN = 16'h0064;
  localparam logic [15:0] ICR_WIN_MAX = 16'h07d0;
  localparam logic [15:0] ICR_WIN_DEFAULT = 16'h03e8;
  localparam logic [31:0] ICR_IP_DEFAULT = 32'hc0a80001;
  localparam logic [31:0] ICR_MASK_DEFAULT = 32'hffffff00;
  localparam logic [31:0] ICR_BOOT_IP_DEFAULT = 32'hc0a800c8;
  localparam logic [31:0] ICR_BOOT_MASK_DEFAULT = 32'hffffff00;
  localparam logic [31:0] ICR_IP_NONE = 32'h00000000;

  function automatic logic icr_in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

endpackage

/* src/icr_dec_if.sv */
interface icr_dec_if;
  logic [7:0] func;
  logic [15:0] addr;
  logic hit;
  icr_pkg::icr_idx_t idx;
  logic fn_rd;
  logic fn_wr;
  modport dec (input func, input addr, output hit, output idx, output fn_rd, output fn_wr);
  modport user (output func, output addr, input hit, input idx, input fn_rd, input fn_wr);
endinterface

/* src/icr_req_decode.sv */
module icr_req_decode (
  icr_dec_if.dec d
);
  import icr_pkg::*;

  always_comb begin
    d.fn_rd = (d.func == ICR_FN_READ);
    d.fn_wr = (d.func == ICR_FN_WRITE);
    d.hit = 1'b1;
    d.idx = ICR_I_CH1_WIN;
    case (d.addr)
      ICR_OFS_CH1_WIN: d.idx = ICR_I_CH1_WIN;
      ICR_OFS_CH1_OSC: d.idx = ICR_I_CH1_OSC;
      ICR_OFS_CH2_WIN: d.idx = ICR_I_CH2_WIN;
      ICR_OFS_DEV_ADDR: d.idx = ICR_I_DEV_ADDR;
      ICR_OFS_RATE: d.idx = ICR_I_RATE;
      ICR_OFS_IP_HI: d.idx = ICR_I_IP_HI;
      ICR_OFS_IP_LO: d.idx = ICR_I_IP_LO;
      ICR_OFS_MASK_HI: d.idx = ICR_I_MASK_HI;
      ICR_OFS_MASK_LO: d.idx = ICR_I_MASK_LO;
      ICR_OFS_DHCP: d.idx = ICR_I_DHCP;
      ICR_OFS_BIP_HI: d.idx = ICR_I_BIP_HI;
      ICR_OFS_BIP_LO: d.idx = ICR_I_BIP_LO;
      ICR_OFS_BMASK_HI: d.idx = ICR_I_BMASK_HI;
      ICR_OFS_BMASK_LO: d.idx = ICR_I_BMASK_LO;
      ICR_OFS_BOOT_SEL: d.idx = ICR_I_BOOT_SEL;
      ICR_OFS_SAVE: d.idx = ICR_I_SAVE;
      default: d.hit = 1'b0;
    endcase
  end

endmodule

/* src/icr_sync2.sv */
module icr_sync2 (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } icr_sync_t;

  icr_sync_t s_r;
  icr_sync_t s_nxt;

  always_comb begin
    s_nxt.meta = din;
    s_nxt.stable = s_r.meta;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.stable;

endmodule

/* src/icr_regs.sv */
// What this block does
// - Rate code 0..6 selects 2400, 4800, 9600, 19200, 38400, 57600, 115200 bps.
// - A new rate code changes the serial link only after a device restart.
// - Factory default rate code is 6, meaning 115200 bps.
// - Multidrop variant accepts device addresses 1 to 254, default 1.
// - A written device address becomes active only after the next restart.
// - Point-to-point and USB variants keep device address fixed at 1.
// - Static IP: lower offset holds first two octets, next holds last two.
// - Static mask: first register upper two octets, next lower two.
// - Network mode 0x0001 selects dynamic addressing; static address and mask ignored.
// - Writing 0x0001 to save trigger stores network settings; used after restart.
// - Bootloader uses 192.168.0.200 when stored parameters are not selected.
// - Bootloader IP and mask each held as two octet pairs, consecutively.
// - Boot select 0x0001 uses stored parameters, 0x0000 uses built-in defaults.
// - Bootloader network settings are static only, never dynamic.
// - Oscillator register: 0x0001 external, 0x0000 internal, for channel 1.
// - Each channel window is 100 to 2000 ms in its own register.
// - A window write takes effect at once, no restart needed.
// - Changing one channel window leaves the other untouched.
// - Registers reached through serial or TCP framing, outside this block.
// - Only read holding (03) and write single (06) functions are served.
// - Reading an unsupported offset returns zero rather than failing.
module icr_regs (
  input wire logic mclk,
  input wire logic reset,
  input wire logic dev_restart,
  input wire logic multidrop_strap,
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [7:0] rsp_exc,
  output logic [2:0] serial_rate_code,
  output logic [7:0] dev_addr,
  output logic [15:0] ch1_window_ms,
  output logic [15:0] ch2_window_ms,
  output logic ch1_ext_osc,
  output logic net_dhcp,
  output logic [31:0] net_ip,
  output logic [31:0] net_mask,
  output logic [31:0] boot_ip,
  output logic [31:0] boot_mask,
  output logic nv_save_pulse
);
  import icr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ICR_NREG-1:0][15:0] regs;
    logic init_done;
    logic [1:0] settle;
    logic multidrop;
    logic nv_dhcp;
    logic nv_boot_sel;
    logic [31:0] nv_ip;
    logic [31:0] nv_mask;
    logic [31:0] nv_boot_ip;
    logic [31:0] nv_boot_mask;
    logic [2:0] act_rate;
    logic [7:0] act_addr;
    logic act_dhcp;
    logic [31:0] act_ip;
    logic [31:0] act_mask;
    logic [31:0] act_boot_ip;
    logic [31:0] act_boot_mask;
    logic nv_save;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic [7:0] rsp_exc;
  } icr_state_t;

  function automatic icr_state_t icr_reset_state();
    icr_state_t r;
    r = '0;
    r.regs[ICR_I_CH1_WIN] = ICR_WIN_DEFAULT;
    r.regs[ICR_I_CH2_WIN] = ICR_WIN_DEFAULT;
    r.regs[ICR_I_CH1_OSC] = ICR_FLAG_OFF;
    r.regs[ICR_I_DEV_ADDR] = ICR_ADDR_DEFAULT;
    r.regs[ICR_I_RATE] = ICR_RATE_DEFAULT;
    r.regs[ICR_I_IP_HI] = ICR_IP_DEFAULT[31:16];
    r.regs[ICR_I_IP_LO] = ICR_IP_DEFAULT[15:0];
    r.regs[ICR_I_MASK_HI] = ICR_MASK_DEFAULT[31:16];
    r.regs[ICR_I_MASK_LO] = ICR_MASK_DEFAULT[15:0];
    r.regs[ICR_I_BIP_HI] = ICR_BOOT_IP_DEFAULT[31:16];
    r.regs[ICR_I_BIP_LO] = ICR_BOOT_IP_DEFAULT[15:0];
    r.regs[ICR_I_BMASK_HI] = ICR_BOOT_MASK_DEFAULT[31:16];
    r.regs[ICR_I_BMASK_LO] = ICR_BOOT_MASK_DEFAULT[15:0];
    r.nv_ip = ICR_IP_DEFAULT;
    r.nv_mask = ICR_MASK_DEFAULT;
    r.nv_boot_ip = ICR_BOOT_IP_DEFAULT;
    r.nv_boot_mask = ICR_BOOT_MASK_DEFAULT;
    r.act_rate = ICR_RATE_DEFAULT[2:0];
    r.act_addr = ICR_ADDR_DEFAULT[7:0];
    r.act_ip = ICR_IP_DEFAULT;
    r.act_mask = ICR_MASK_DEFAULT;
    r.act_boot_ip = ICR_BOOT_IP_DEFAULT;
    r.act_boot_mask = ICR_BOOT_MASK_DEFAULT;
    return r;
  endfunction

  localparam logic [1:0] ICR_SETTLE_LAST = 2'h2;
  localparam icr_state_t ICR_STATE_RST = icr_reset_state();

  icr_state_t s_r;
  icr_state_t s_nxt;
  logic multidrop_sync;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  icr_dec_if dec ();

  assign dec.func = req_func;
  assign dec.addr = req_addr;

  icr_req_decode u_dec (
    .d(dec.dec)
  );

  // The variant strap comes from a pin, so it is synchronised first.
  icr_sync2 u_strap (
    .mclk(mclk),
    .reset(reset),
    .din(multidrop_strap),
    .dout(multidrop_sync)
  );

  function automatic logic is_flag(input logic [15:0] v);
    return (v == ICR_FLAG_ON) || (v == ICR_FLAG_OFF);
  endfunction

  // Decides whether a write value is legal for the addressed register.
  function automatic logic value_ok(input icr_idx_t idx, input logic [15:0] v, input logic md);
    logic ok;
    ok = 1'b1;
    case (idx)
      ICR_I_RATE: ok = (v <= ICR_RATE_MAX);
      ICR_I_DEV_ADDR: ok = md && icr_in_range(v, ICR_ADDR_MIN, ICR_ADDR_MAX);
      ICR_I_CH1_WIN: ok = icr_in_range(v, ICR_WIN_MIN, ICR_WIN_MAX);
      ICR_I_CH2_WIN: ok = icr_in_range(v, ICR_WIN_MIN, ICR_WIN_MAX);
      ICR_I_CH1_OSC: ok = is_flag(v);
      ICR_I_DHCP: ok = is_flag(v);
      ICR_I_BOOT_SEL: ok = is_flag(v);
      ICR_I_SAVE: ok = is_flag(v);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.rsp_data = '0;
    s_nxt.rsp_exc = ICR_EX_NONE;
    s_nxt.nv_save = 1'b0;

    // The synchroniser restarts with the block, so the strap is followed until it has refilled, then frozen.
    if (!s_r.init_done) begin
      s_nxt.settle = 2'(s_r.settle + 2'h1);
      s_nxt.init_done = (s_r.settle == ICR_SETTLE_LAST);
      s_nxt.multidrop = multidrop_sync;
    end

    // A device restart applies the pending link settings and the stored
    // network image; the stored image only changes through the save trigger.
    if (dev_restart) begin
      s_nxt.act_rate = s_r.regs[ICR_I_RATE][2:0];
      s_nxt.act_addr = s_r.multidrop ? s_r.regs[ICR_I_DEV_ADDR][7:0] : ICR_ADDR_DEFAULT[7:0];
      s_nxt.act_dhcp = s_r.nv_dhcp;
      s_nxt.act_ip = s_r.nv_dhcp ? ICR_IP_NONE : s_r.nv_ip;
      s_nxt.act_mask = s_r.nv_dhcp ? ICR_IP_NONE : s_r.nv_mask;
      // The boot image carries no dynamic option at all.
      s_nxt.act_boot_ip = s_r.nv_boot_sel ? s_r.nv_boot_ip : ICR_BOOT_IP_DEFAULT;
      s_nxt.act_boot_mask = s_r.nv_boot_sel ? s_r.nv_boot_mask : ICR_BOOT_MASK_DEFAULT;
    end

    if (req_valid) begin
      s_nxt.rsp_valid = 1'b1;
      if (dec.fn_rd) begin
        // Unknown offsets and the write-only trigger read as zero.
        if (dec.hit && (dec.idx != ICR_I_SAVE)) begin
          s_nxt.rsp_data = s_r.regs[dec.idx];
        end else begin
          s_nxt.rsp_data = '0;
        end
      end else if (dec.fn_wr) begin
        if (!dec.hit) begin
          s_nxt.rsp_exc = ICR_EX_ADDR;
        end else if (!value_ok(dec.idx, req_wdata, s_r.multidrop)) begin
          s_nxt.rsp_exc = ICR_EX_VALUE;
        end else begin
          s_nxt.rsp_data = req_wdata;
          if (dec.idx != ICR_I_SAVE) begin
            s_nxt.regs[dec.idx] = req_wdata;
          end else if (req_wdata == ICR_FLAG_ON) begin
            s_nxt.nv_save = 1'b1;
            s_nxt.nv_ip = {s_r.regs[ICR_I_IP_HI], s_r.regs[ICR_I_IP_LO]};
            s_nxt.nv_mask = {s_r.regs[ICR_I_MASK_HI], s_r.regs[ICR_I_MASK_LO]};
            s_nxt.nv_dhcp = (s_r.regs[ICR_I_DHCP] == ICR_FLAG_ON);
            s_nxt.nv_boot_ip = {s_r.regs[ICR_I_BIP_HI], s_r.regs[ICR_I_BIP_LO]};
            s_nxt.nv_boot_mask = {s_r.regs[ICR_I_BMASK_HI], s_r.regs[ICR_I_BMASK_LO]};
            s_nxt.nv_boot_sel = (s_r.regs[ICR_I_BOOT_SEL] == ICR_FLAG_ON);
          end
        end
      end else begin
        s_nxt.rsp_exc = ICR_EX_FUNC;
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r <= ICR_STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rsp_valid = s_r.rsp_valid;
  assign rsp_data = s_r.rsp_data;
  assign rsp_exc = s_r.rsp_exc;
  assign serial_rate_code = s_r.act_rate;
  assign dev_addr = s_r.act_addr;
  assign ch1_window_ms = s_r.regs[ICR_I_CH1_WIN];
  assign ch2_window_ms = s_r.regs[ICR_I_CH2_WIN];
  assign ch1_ext_osc = s_r.regs[ICR_I_CH1_OSC][0];
  assign net_dhcp = s_r.act_dhcp;
  assign net_ip = s_r.act_ip;
  assign net_mask = s_r.act_mask;
  assign boot_ip = s_r.act_boot_ip;
  assign boot_mask = s_r.act_boot_mask;
  assign nv_save_pulse = s_r.nv_save;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_RATE_HOLD:
    assert property (!dev_restart |=> $stable(serial_rate_code))
    else $error("serial rate changed without a restart");

  AST_RATE_RANGE:
    assert property (serial_rate_code <= ICR_RATE_MAX[2:0])
    else $error("serial rate code out of range");

  AST_ADDR_FIXED:
    assert property (s_r.init_done && !s_r.multidrop |-> dev_addr == ICR_ADDR_DEFAULT[7:0])
    else $error("fixed variant address is not one");

  AST_ADDR_APPLY:
    assert property (dev_restart && s_r.multidrop |=> dev_addr == $past(s_r.regs[ICR_I_DEV_ADDR][7:0]))
    else $error("restart did not apply device address");

  AST_WIN_NOW:
    assert property (req_valid && dec.fn_wr && dec.hit && dec.idx == ICR_I_CH1_WIN
                     && icr_in_range(req_wdata, ICR_WIN_MIN, ICR_WIN_MAX)
                     |=> ch1_window_ms == $past(req_wdata))
    else $error("channel 1 window not updated at once");

  AST_WIN_OTHER:
    assert property (req_valid && dec.fn_wr && dec.idx == ICR_I_CH1_WIN |=> $stable(ch2_window_ms))
    else $error("channel 2 window disturbed by channel 1 write");

  AST_UNMAPPED_RD:
    assert property (req_valid && dec.fn_rd && !dec.hit |=> rsp_valid && rsp_data == '0 && rsp_exc == ICR_EX_NONE)
    else $error("unmapped read did not return zero");

  AST_BAD_FUNC:
    assert property (req_valid && !dec.fn_rd && !dec.fn_wr |=> rsp_valid && rsp_exc == ICR_EX_FUNC)
    else $error("unsupported function not refused");

  AST_SAVE_PULSE:
    assert property (req_valid && dec.fn_wr && dec.hit && dec.idx == ICR_I_SAVE && req_wdata == ICR_FLAG_ON
                     |=> nv_save_pulse ##1 (!nv_save_pulse || $past(req_valid && dec.fn_wr && dec.idx == ICR_I_SAVE)))
    else $error("save trigger pulse wrong");

  AST_BOOT_DEFAULT:
    assert property (dev_restart && !s_r.nv_boot_sel |=> boot_ip == ICR_BOOT_IP_DEFAULT)
    else $error("boot address not default when unselected");

  AST_DHCP_IGNORES:
    assert property (net_dhcp |-> net_ip == ICR_IP_NONE && net_mask == ICR_IP_NONE)
    else $error("static address used with dynamic mode");

  AST_READBACK:
    assert property (req_valid && dec.fn_wr && dec.hit && dec.idx == ICR_I_RATE && req_wdata <= ICR_RATE_MAX
                     ##1 (req_valid && dec.fn_rd && dec.idx == ICR_I_RATE && !dev_restart)
                     |=> rsp_data == $past(req_wdata, 2))
    else $error("rate register read-back wrong");

  AST_WIN2_NOW:
    assert property (req_valid && dec.fn_wr && dec.hit && dec.idx == ICR_I_CH2_WIN
                     && icr_in_range(req_wdata, ICR_WIN_MIN, ICR_WIN_MAX) |=> ch2_window_ms == $past(req_wdata))
    else $error("ch2 window not immediate");

  AST_WIN2_OTHER:
    assert property (req_valid && dec.fn_wr && dec.idx == ICR_I_CH2_WIN |=> $stable(ch1_window_ms))
    else $error("ch1 window disturbed");

  AST_WIN_RANGE:
    assert property (icr_in_range(ch1_window_ms, ICR_WIN_MIN, ICR_WIN_MAX)
                     && icr_in_range(ch2_window_ms, ICR_WIN_MIN, ICR_WIN_MAX))
    else $error("window out of range");

  AST_ADDR_RANGE:
    assert property (icr_in_range({8'h00, dev_addr}, ICR_ADDR_MIN, ICR_ADDR_MAX))
    else $error("address out of range");

  AST_ADDR_REFUSE:
    assert property (req_valid && dec.fn_wr && dec.idx == ICR_I_DEV_ADDR
                     && !icr_in_range(req_wdata, ICR_ADDR_MIN, ICR_ADDR_MAX) |=> rsp_exc == ICR_EX_VALUE)
    else $error("bad address not refused");

  AST_OSC_NOW:
    assert property (req_valid && dec.fn_wr && dec.idx == ICR_I_CH1_OSC && is_flag(req_wdata)
                     |=> ch1_ext_osc == $past(req_wdata[0]))
    else $error("oscillator not immediate");

  AST_BOOT_STORED:
    assert property (dev_restart && s_r.nv_boot_sel |=> boot_ip == $past(s_r.nv_boot_ip))
    else $error("stored boot address unused");

  AST_SAVE_IDLE:
    assert property (!(req_valid && dec.fn_wr && dec.idx == ICR_I_SAVE) |=> !nv_save_pulse)
    else $error("stray save pulse");

  AST_RSP_ONCE:
    assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");

endmodule

/* test/icr_host_model.sv */
module icr_host_model (
  input wire logic mclk,
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [7:0] rsp_exc
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end

  // ----------------------------------------------------------------
  // One master transaction
  // ----------------------------------------------------------------
  // Released request lines carry inverted values so that a stale field is never mistaken for a live one.
  task automatic xfer(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] wd,
                      output logic [15:0] rd, output logic [7:0] ex, output logic hung);
    int n;
    hung = 1'b1;
    rd = 16'h0000;
    ex = 8'hff;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_func <= fn;
    req_addr <= ad;
    req_wdata <= wd;
    @(posedge mclk);
    req_valid <= 1'b0;
    req_func <= ~fn;
    req_addr <= ~ad;
    req_wdata <= ~wd;
    for (n = 0; n < 4 && hung === 1'b1; n++) begin
      @(negedge mclk);
      if (rsp_valid === 1'b1) begin
        rd = rsp_data;
        ex = rsp_exc;
        hung = 1'b0;
      end
    end
  endtask

  // A write and a read of one register on consecutive edges; returns the read answer.
  task automatic xfer2(input logic [15:0] ad, input logic [15:0] wd, output logic [15:0] rd, output logic hung);
    hung = 1'b1;
    rd = 16'h0000;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_func <= 8'h06;
    req_addr <= ad;
    req_wdata <= wd;
    @(posedge mclk);
    req_func <= 8'h03;
    @(posedge mclk);
    req_valid <= 1'b0;
    req_func <= 8'hfc;
    req_addr <= ~ad;
    req_wdata <= ~wd;
    @(negedge mclk);
    if (rsp_valid === 1'b1) begin
      rd = rsp_data;
      hung = 1'b0;
    end
  endtask
endmodule

/* test/instrument_config_registers_test.sv */
module instrument_config_registers_test;
  timeunit 1ns;
  timeprecision 1ns;
  import icr_pkg::*;

  typedef struct packed {
    logic [7:0] fn;
    logic [15:0] ad;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [7:0] ex;
  } icr_row_t;

  localparam logic [7:0] RD = ICR_FN_READ;
  localparam logic [7:0] WR = ICR_FN_WRITE;

  logic mclk;
  logic reset;
  logic dev_restart;
  logic multidrop_strap;
  logic req_valid;
  logic [7:0] req_func;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [7:0] rsp_exc;
  logic [2:0] serial_rate_code;
  logic [7:0] dev_addr;
  logic [15:0] ch1_window_ms;
  logic [15:0] ch2_window_ms;
  logic ch1_ext_osc;
  logic net_dhcp;
  logic [31:0] net_ip;
  logic [31:0] net_mask;
  logic [31:0] boot_ip;
  logic [31:0] boot_mask;
  logic nv_save_pulse;
  logic [15:0] rd;
  logic [7:0] ex;
  logic hung;
  int errors;
  int samples_checked;

  icr_row_t rows [0:31] = '{
    '{RD, 16'h0022, 16'h0000, 16'h0006, 8'h00},
    '{RD, 16'h0021, 16'h0000, 16'h0001, 8'h00},
    '{WR, 16'h0004, 16'h0064, 16'h0064, 8'h00},
    '{WR, 16'h0014, 16'h07d0, 16'h07d0, 8'h00},
    '{WR, 16'h0004, 16'h0063, 16'h0000, 8'h03},
    '{WR, 16'h0014, 16'h07d1, 16'h0000, 8'h03},
    '{RD, 16'h0004, 16'h0000, 16'h0064, 8'h00},
    '{RD, 16'h0014, 16'h0000, 16'h07d0, 8'h00},
    '{WR, 16'h0022, 16'h0007, 16'h0000, 8'h03},
    '{WR, 16'h0022, 16'h0002, 16'h0002, 8'h00},
    '{RD, 16'h0022, 16'h0000, 16'h0002, 8'h00},
    '{WR, 16'h0021, 16'h00ff, 16'h0000, 8'h03},
    '{WR, 16'h0021, 16'h0000, 16'h0000, 8'h03},
    '{WR, 16'h0021, 16'h00fe, 16'h00fe, 8'h00},
    '{RD, 16'h0021, 16'h0000, 16'h00fe, 8'h00},
    '{8'h10, 16'h0004, 16'h0001, 16'h0000, 8'h01},
    '{8'h04, 16'h0004, 16'h0000, 16'h0000, 8'h01},
    '{RD, 16'h0050, 16'h0000, 16'h0000, 8'h00},
    '{WR, 16'h0050, 16'h0001, 16'h0000, 8'h02},
    '{RD, 16'h0043, 16'h0000, 16'h0000, 8'h00},
    '{WR, 16'h0006, 16'h0002, 16'h0000, 8'h03},
    '{WR, 16'h0006, 16'h0001, 16'h0001, 8'h00},
    '{WR, 16'h0031, 16'h0a00, 16'h0a00, 8'h00},
    '{WR, 16'h0032, 16'h0005, 16'h0005, 8'h00},
    '{WR, 16'h0033, 16'hffff, 16'hffff, 8'h00},
    '{WR, 16'h0034, 16'hfc00, 16'hfc00, 8'h00},
    '{WR, 16'h003c, 16'h0a01, 16'h0a01, 8'h00},
    '{WR, 16'h003d, 16'h0002, 16'h0002, 8'h00},
    '{WR, 16'h003e, 16'hffff, 16'hffff, 8'h00},
    '{WR, 16'h003f, 16'hff80, 16'hff80, 8'h00},
    '{WR, 16'h0042, 16'h0001, 16'h0001, 8'h00},
    '{RD, 16'h0032, 16'h0000, 16'h0005, 8'h00}
  };

  icr_regs uut (
    .mclk, .reset, .dev_restart, .multidrop_strap, .req_valid, .req_func, .req_addr, .req_wdata,
    .rsp_valid, .rsp_data, .rsp_exc, .serial_rate_code, .dev_addr, .ch1_window_ms, .ch2_window_ms,
    .ch1_ext_osc, .net_dhcp, .net_ip, .net_mask, .boot_ip, .boot_mask, .nv_save_pulse
  );

  icr_host_model host (
    .mclk, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid, .rsp_data, .rsp_exc
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic req(input logic [7:0] fn, input logic [15:0] ad, input logic [15:0] wd);
    logic hung;
    host.xfer(fn, ad, wd, rd, ex, hung);
    if (hung !== 1'b0) begin
      errors++;
      $display("[ERR] rsp_valid expected 1 seen 0");
      close_out();
    end
  endtask

  // The restart pulse spans exactly one taking edge; outputs are read once it has landed.
  task automatic restart();
    @(posedge mclk);
    dev_restart <= 1'b1;
    @(posedge mclk);
    dev_restart <= 1'b0;
    @(negedge mclk);
  endtask

  // The strap is set at the start of reset; the synchroniser is held clear until release and refills in the settle window after it.
  task automatic power_up(input logic strap);
    @(posedge mclk);
    reset <= 1'b1;
    multidrop_strap <= strap;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic defaults();
    chk("serial_rate_code", 32'(ICR_RATE_DEFAULT), 32'(serial_rate_code));
    chk("dev_addr", 32'(ICR_ADDR_DEFAULT), 32'(dev_addr));
    chk("ch1_window_ms", 32'(ICR_WIN_DEFAULT), 32'(ch1_window_ms));
    chk("ch2_window_ms", 32'(ICR_WIN_DEFAULT), 32'(ch2_window_ms));
    chk("ch1_ext_osc", 32'h0, 32'(ch1_ext_osc));
    chk("net_dhcp", 32'h0, 32'(net_dhcp));
    chk("net_ip", ICR_IP_DEFAULT, net_ip);
    chk("net_mask", ICR_MASK_DEFAULT, net_mask);
    chk("boot_ip", ICR_BOOT_IP_DEFAULT, boot_ip);
    chk("boot_mask", ICR_BOOT_MASK_DEFAULT, boot_mask);
    chk("nv_save_pulse", 32'h0, 32'(nv_save_pulse));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    dev_restart = 1'b0;
    multidrop_strap = 1'b1;
    errors = 0;
    samples_checked = 0;
    power_up(1'b1);
    defaults();
    foreach (rows[i]) begin
      req(rows[i].fn, rows[i].ad, rows[i].wd);
      chk("rsp_data", 32'(rows[i].rd), 32'(rd));
      chk("rsp_exc", 32'(rows[i].ex), 32'(ex));
    end
    chk("serial_rate_code", 32'h6, 32'(serial_rate_code));
    chk("dev_addr", 32'h1, 32'(dev_addr));
    chk("ch1_window_ms", 32'h64, 32'(ch1_window_ms));
    chk("ch2_window_ms", 32'h7d0, 32'(ch2_window_ms));
    chk("ch1_ext_osc", 32'h1, 32'(ch1_ext_osc));
    restart();
    chk("serial_rate_code", 32'h2, 32'(serial_rate_code));
    chk("dev_addr", 32'hfe, 32'(dev_addr));
    chk("net_ip", ICR_IP_DEFAULT, net_ip);
    chk("boot_ip", ICR_BOOT_IP_DEFAULT, boot_ip);
    req(WR, 16'h0043, 16'h0001);
    chk("nv_save_pulse", 32'h1, 32'(nv_save_pulse));
    restart();
    chk("net_ip", 32'h0a000005, net_ip);
    chk("net_mask", 32'hfffffc00, net_mask);
    chk("boot_ip", 32'h0a010002, boot_ip);
    chk("boot_mask", 32'hffffff80, boot_mask);
    req(WR, 16'h003a, 16'h0001);
    req(WR, 16'h0043, 16'h0001);
    restart();
    chk("net_dhcp", 32'h1, 32'(net_dhcp));
    chk("net_ip", ICR_IP_NONE, net_ip);
    chk("boot_ip", 32'h0a010002, boot_ip);
    req(WR, 16'h0042, 16'h0000);
    req(WR, 16'h0043, 16'h0001);
    restart();
    chk("boot_ip", ICR_BOOT_IP_DEFAULT, boot_ip);
    req(WR, 16'h0006, 16'h0000);
    chk("ch1_ext_osc", 32'h0, 32'(ch1_ext_osc));
    host.xfer2(16'h0022, 16'h0003, rd, hung);
    chk("rsp_valid", 32'h1, 32'(!hung));
    chk("rsp_data", 32'h3, 32'(rd));
    for (int c = 0; c <= 6; c++) begin
      req(WR, 16'h0022, 16'(c));
      restart();
      chk("serial_rate_code", 32'(c), 32'(serial_rate_code));
    end
    power_up(1'b0);
    defaults();
    req(WR, 16'h0021, 16'h0005);
    chk("rsp_exc", 32'h3, 32'(ex));
    restart();
    chk("dev_addr", 32'h1, 32'(dev_addr));
    close_out();
  end
endmodule
